/* src/atm_map.svh */
/*
 * constants for the analogue threshold monitor: option bit positions,
 * curve geometry, preset curve points, register offsets and reset values.
 * assumes inclusion by bare name from the design only.
 */
`ifndef ATM_MAP_SVH
`define ATM_MAP_SVH

// option bit positions
`define ATM_OPT_BELOW 0
`define ATM_OPT_POL 1
`define ATM_OPT_WARN 4
`define ATM_OPT_DEACT 6
`define ATM_OPT_LOCK 7
`define ATM_OPT_RUN 8
`define ATM_OPT_OILMASK 9
`define ATM_OPT_BRK 10
`define ATM_OPT_FUEL 11
`define ATM_OPT_INHIBIT 13
`define ATM_OPT_PUMP 14

// curve geometry
`define ATM_CURVE_POINTS 32
`define ATM_CURVE_IDX_W 5

// register offsets (own map)
`define ATM_REG_FUNC 8'h00
`define ATM_REG_THR0_VAL 8'h01
`define ATM_REG_THR0_DLY 8'h02
`define ATM_REG_THR0_OPT 8'h03
`define ATM_REG_THR1_VAL 8'h04
`define ATM_REG_THR1_DLY 8'h05
`define ATM_REG_THR1_OPT 8'h06
`define ATM_REG_NPTS 8'h07
`define ATM_REG_STATUS 8'h08
`define ATM_REG_MEASURE 8'h09
`define ATM_REG_CURVE_BASE 8'h40
`define ATM_REG_CURVE_RAW_BIT 5

// reset values
`define ATM_RST_FUNC 3'h0
`define ATM_RST_VAL 16'h0000
`define ATM_RST_DLY 16'h0000
`define ATM_RST_OPT 16'h0000
`define ATM_RST_NPTS 6'h02

// preset temperature curve: raw ohm falling, value degC rising
`define ATM_T_R0 16'h0708
`define ATM_T_R1 16'h00c3
`define ATM_T_R2 16'h0026
`define ATM_T_R3 16'h000a
`define ATM_T_V0 16'h0000
`define ATM_T_V1 16'h0032
`define ATM_T_V2 16'h0064
`define ATM_T_V3 16'h0096
// preset pressure curve: ohm to bar
`define ATM_P_R0 16'h000a
`define ATM_P_R1 16'h00b4
`define ATM_P_V0 16'h0000
`define ATM_P_V1 16'h000a
// preset level curve: ohm to percent
`define ATM_L_R0 16'h00b4
`define ATM_L_R1 16'h000a
`define ATM_L_V0 16'h0000
`define ATM_L_V1 16'h0064

`endif

/* src/atm_pkg.sv */
/*
 * types shared by the analogue threshold monitor and its bench.
 * assumes atm_map.svh on the include path.
 */
package atm_pkg;
	// input function selection
	typedef enum logic [2:0] {
		ATM_FN_GENERIC_DISPLAYED,
		ATM_FN_GENERIC_HIDDEN,
		ATM_FN_PRESSURE,
		ATM_FN_OIL_TEMP,
		ATM_FN_COOLANT_TEMP,
		ATM_FN_OIL_LEVEL,
		ATM_FN_COOLANT_LEVEL,
		ATM_FN_FUEL_LEVEL
	} atm_func_t;

	// one threshold's configuration
	typedef struct packed {
		logic [15:0] value;
		logic [15:0] delay;
		logic [15:0] opt;
	} atm_thr_cfg_t;

	// engine-side conditions
	typedef struct packed {
		logic engine_running;
		logic oil_mask_expired;
		logic breaker_closed;
		logic fuel_valve_on;
		logic inhibit_present;
		logic inhibit_active;
	} atm_cond_t;

	// per-threshold results
	typedef struct packed {
		logic status;
		logic fault;
		logic warn;
		logic deact;
		logic lock;
		logic pump_off;
	} atm_act_t;
endpackage : atm_pkg

/* src/atm_monitor.sv */
/*
 * analogue threshold monitor for one input: curve conversion of the raw
 * sample, two independent delayed thresholds and their gated actions.
 * assumes raw samples and engine conditions come from logic on clk_in;
 * registers reached over a plain strobe port, read data one cycle later.
 */
`timescale 1ns/1ns
`include "atm_map.svh"

// Functional notes
// - two thresholds evaluated fully independently, own value, delay, options.
// - option bit 0 clear trips above value, set trips below value.
// - option bit 1 sets internal status level while out of threshold.
// - option bit 4 raises warning while out of threshold.
// - option bit 6 raises deactivation command while out of threshold.
// - option bit 7 raises lock command while out of threshold.
// - option bit 8 allows fault only while engine runs.
// - option bit 9 allows fault only after oil pressure masking expired.
// - option bit 10 issues warning or lock only with breaker closed.
// - option bit 11 allows fault only while fuel valve active.
// - option bit 13 blocks warning, deactivation and lock while an inhibit input is both present and active.
// - option bit 14 makes an asserted fault force fuel pump off.
// - any option combination applies all enabled actions and gates together.
// - each threshold has its own programmable delay before acting.
// - independent of protection-menu thresholds; both may act on one measure.
// - hidden generic sensor measure still drives thresholds, not display.
// - conversion curve holds at most 32 raw to value points.
// - first and last segments extend indefinitely beyond curve ends.
// - preset temperature 0,50,100,150 degC at 1800,195,38,10 ohm.
// - preset pressure 0 bar at 10 ohm, 10 bar at 180 ohm.
// - preset levels 0 percent at 180 ohm, 100 percent at 10 ohm.
module atm_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	input wire logic [15:0] raw_in,
	input wire logic raw_valid_in,
	input wire atm_pkg::atm_cond_t cond_in,
	output logic [15:0] measure_out,
	output logic display_en_out,
	output atm_pkg::atm_act_t [1:0] act_out
);
	localparam int NP = `ATM_CURVE_POINTS;

	// configuration registers
	atm_pkg::atm_func_t func_reg;
	// unpacked, so each threshold copy owns its own element
	atm_pkg::atm_thr_cfg_t cfg_reg [2];
	logic [5:0] npts_reg;
	logic [15:0] craw_reg [NP];
	logic [15:0] cval_reg [NP];
	logic [15:0] measure_reg;
	logic [15:0] rdata_reg;
	atm_pkg::atm_act_t act_reg [2];
	logic [15:0] timer_reg [2];

	// register decode
	wire sel_curve = addr_in[7:6] == 2'b01;
	wire [4:0] curve_idx = addr_in[4:0];
	wire curve_raw = ~addr_in[`ATM_REG_CURVE_RAW_BIT];
	wire wr_func = wr_in && addr_in == `ATM_REG_FUNC;
	wire wr_npts = wr_in && addr_in == `ATM_REG_NPTS;

	// active curve: presets or programmed points
	logic [15:0] pr [4];
	logic [15:0] pv [4];
	logic [5:0] act_n;
	logic use_preset;
	always_comb begin
		use_preset = 1'b1;
		act_n = 6'd2;
		pr[0] = `ATM_L_R0;
		pr[1] = `ATM_L_R1;
		pr[2] = 16'h0000;
		pr[3] = 16'h0000;
		pv[0] = `ATM_L_V0;
		pv[1] = `ATM_L_V1;
		pv[2] = 16'h0000;
		pv[3] = 16'h0000;
		case (func_reg)
			atm_pkg::ATM_FN_PRESSURE: begin
				pr[0] = `ATM_P_R0;
				pr[1] = `ATM_P_R1;
				pv[0] = `ATM_P_V0;
				pv[1] = `ATM_P_V1;
			end
			atm_pkg::ATM_FN_OIL_TEMP, atm_pkg::ATM_FN_COOLANT_TEMP: begin
				act_n = 6'd4;
				pr[0] = `ATM_T_R0;
				pr[1] = `ATM_T_R1;
				pr[2] = `ATM_T_R2;
				pr[3] = `ATM_T_R3;
				pv[0] = `ATM_T_V0;
				pv[1] = `ATM_T_V1;
				pv[2] = `ATM_T_V2;
				pv[3] = `ATM_T_V3;
			end
			atm_pkg::ATM_FN_OIL_LEVEL, atm_pkg::ATM_FN_COOLANT_LEVEL,
			atm_pkg::ATM_FN_FUEL_LEVEL: begin
				act_n = 6'd2;
			end
			atm_pkg::ATM_FN_GENERIC_DISPLAYED, atm_pkg::ATM_FN_GENERIC_HIDDEN: begin
				use_preset = 1'b0;
				act_n = npts_reg;
			end
			default: begin
				use_preset = 1'b1;
			end
		endcase
	end

	function automatic logic [15:0] pt_raw(input logic pre, input logic [4:0] i,
			input logic [15:0] p0, input logic [15:0] p1,
			input logic [15:0] p2, input logic [15:0] p3, input logic [15:0] c);
		logic [15:0] r;
		r = c;
		if (pre) begin
			case (i[1:0])
				2'd0: r = p0;
				2'd1: r = p1;
				2'd2: r = p2;
				default: r = p3;
			endcase
		end
		return r;
	endfunction : pt_raw

	// segment search: first segment whose far end the raw value has not passed
	// points may run rising or falling, so direction comes from the ends
	logic [4:0] seg;
	logic [15:0] r_a, r_b, v_a, v_b;
	logic rising;
	always_comb begin
		logic [4:0] last;
		logic [15:0] rb;
		rb = 16'h0000;
		last = 5'(act_n - 6'd1);
		rising = pt_raw(use_preset, last, pr[0], pr[1], pr[2], pr[3], craw_reg[last]) >=
			pt_raw(use_preset, 5'd0, pr[0], pr[1], pr[2], pr[3], craw_reg[0]);
		seg = 5'(act_n - 6'd2);
		for (int i = NP - 2; i >= 0; i--) begin
			rb = pt_raw(use_preset, 5'(i + 1), pr[0], pr[1], pr[2], pr[3], craw_reg[i + 1]);
			if (i < int'(act_n) - 1 && (rising ? raw_in <= rb : raw_in >= rb)) begin
				seg = 5'(i);
			end
		end
		r_a = pt_raw(use_preset, seg, pr[0], pr[1], pr[2], pr[3], craw_reg[seg]);
		r_b = pt_raw(use_preset, 5'(seg + 5'd1), pr[0], pr[1], pr[2], pr[3],
			craw_reg[5'(seg + 5'd1)]);
		v_a = pt_raw(use_preset, seg, pv[0], pv[1], pv[2], pv[3], cval_reg[seg]);
		v_b = pt_raw(use_preset, 5'(seg + 5'd1), pv[0], pv[1], pv[2], pv[3],
			cval_reg[5'(seg + 5'd1)]);
	end

	// linear interpolation; the divider is combinational, traded for latency
	logic signed [33:0] num;
	logic signed [17:0] den;
	logic signed [33:0] conv;
	always_comb begin
		num = 34'(($signed({2'b00, raw_in}) - $signed({2'b00, r_a})) *
			($signed({2'b00, v_b}) - $signed({2'b00, v_a})));
		den = 18'($signed({2'b00, r_b}) - $signed({2'b00, r_a}));
		if (den == 18'sh0) begin
			conv = 34'($signed({2'b00, v_a}));
		end else begin
			conv = 34'(num / den) + 34'($signed({2'b00, v_a}));
		end
	end
	// negative results clamp to zero, overflow clamps to full scale
	wire [15:0] conv_sat = conv < 0 ? 16'h0000 :
		(conv > 34'sh0ffff ? 16'hffff : conv[15:0]);

	// conversion register; hidden generic sensor still feeds thresholds
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			measure_reg <= 16'h0000;
		end else if (raw_valid_in) begin
			measure_reg <= conv_sat;
		end
	end

	// configuration writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			func_reg <= atm_pkg::atm_func_t'(`ATM_RST_FUNC);
			npts_reg <= `ATM_RST_NPTS;
		end else begin
			if (wr_func) func_reg <= atm_pkg::atm_func_t'(wdata_in[2:0]);
			if (wr_npts) begin
				// fewer than two points leaves no segment; clamp to 2..32
				if (wdata_in < 16'h0002) npts_reg <= 6'd2;
				else if (wdata_in > 16'h0020) npts_reg <= 6'd32;
				else npts_reg <= wdata_in[5:0];
			end
		end
	end

	// curve point storage
	always_ff @(posedge clk_in) begin
		if (wr_in && sel_curve && curve_raw) craw_reg[curve_idx] <= wdata_in;
		if (wr_in && sel_curve && !curve_raw) cval_reg[curve_idx] <= wdata_in;
	end

	// per-threshold logic, one copy per threshold
	logic [1:0] oot;
	logic [1:0] qual;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : thr
			localparam logic [7:0] BASE = 8'(`ATM_REG_THR0_VAL + 3 * g);
			wire [15:0] opt = cfg_reg[g].opt;
			wire above = measure_reg > cfg_reg[g].value;
			wire below = measure_reg < cfg_reg[g].value;
			wire out_now = opt[`ATM_OPT_BELOW] ? below : above;
			wire done = timer_reg[g] >= cfg_reg[g].delay;
			wire fault_gate = (!opt[`ATM_OPT_RUN] || cond_in.engine_running) &&
				(!opt[`ATM_OPT_OILMASK] || cond_in.oil_mask_expired) &&
				(!opt[`ATM_OPT_FUEL] || cond_in.fuel_valve_on);
			wire inh_ok = !opt[`ATM_OPT_INHIBIT] ||
				!cond_in.inhibit_present || !cond_in.inhibit_active;
			wire brk_ok = !opt[`ATM_OPT_BRK] || cond_in.breaker_closed;
			wire fault = qual[g] && fault_gate;
			assign oot[g] = out_now;

			// config writes for this threshold
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					cfg_reg[g].value <= `ATM_RST_VAL;
					cfg_reg[g].delay <= `ATM_RST_DLY;
					cfg_reg[g].opt <= `ATM_RST_OPT;
				end else if (wr_in) begin
					if (addr_in == BASE) cfg_reg[g].value <= wdata_in;
					if (addr_in == 8'(BASE + 8'd1)) cfg_reg[g].delay <= wdata_in;
					if (addr_in == 8'(BASE + 8'd2)) cfg_reg[g].opt <= wdata_in;
				end
			end

			// persistence timer, restarts whenever the measure is back inside
			always_ff @(posedge clk_in) begin
				if (rst_in || !out_now) begin
					timer_reg[g] <= 16'h0000;
				end else if (!done) begin
					timer_reg[g] <= timer_reg[g] + 16'h0001;
				end
			end
			assign qual[g] = out_now && done;

			// action register, outputs held in flops
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					act_reg[g] <= '0;
				end else begin
					act_reg[g].status <= qual[g] ? opt[`ATM_OPT_POL] : ~opt[`ATM_OPT_POL];
					act_reg[g].fault <= fault;
					act_reg[g].warn <= fault && opt[`ATM_OPT_WARN] && brk_ok && inh_ok;
					act_reg[g].deact <= fault && opt[`ATM_OPT_DEACT] && inh_ok;
					act_reg[g].lock <= fault && opt[`ATM_OPT_LOCK] && brk_ok && inh_ok;
					act_reg[g].pump_off <= fault && opt[`ATM_OPT_PUMP];
				end
			end
		end
	endgenerate

	// read mux; unmapped addresses read zero
	wire [1:0] oot_q = oot;
	wire [15:0] status_word = {4'h0, act_reg[1], act_reg[0]};
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		case (addr_in)
			`ATM_REG_FUNC: rd_mux = {13'h0000, func_reg};
			`ATM_REG_THR0_VAL: rd_mux = cfg_reg[0].value;
			`ATM_REG_THR0_DLY: rd_mux = cfg_reg[0].delay;
			`ATM_REG_THR0_OPT: rd_mux = cfg_reg[0].opt;
			`ATM_REG_THR1_VAL: rd_mux = cfg_reg[1].value;
			`ATM_REG_THR1_DLY: rd_mux = cfg_reg[1].delay;
			`ATM_REG_THR1_OPT: rd_mux = cfg_reg[1].opt;
			`ATM_REG_NPTS: rd_mux = {10'h000, npts_reg};
			`ATM_REG_STATUS: rd_mux = status_word | {oot_q, 14'h0000};
			`ATM_REG_MEASURE: rd_mux = measure_reg;
			default: begin
				if (sel_curve) rd_mux = curve_raw ? craw_reg[curve_idx] : cval_reg[curve_idx];
			end
		endcase
	end

	// read data stands the cycle after the strobe only
	always_ff @(posedge clk_in) begin
		if (rst_in) rdata_reg <= 16'h0000;
		else rdata_reg <= rd_in ? rd_mux : 16'h0000;
	end

	assign rdata_out = rdata_reg;
	assign measure_out = measure_reg;
	assign display_en_out = func_reg != atm_pkg::ATM_FN_GENERIC_HIDDEN;
	assign act_out = {act_reg[1], act_reg[0]};
endmodule : atm_monitor

/* dv/atm_engine_model.sv */
/*
 * far-side model: engine, breaker, fuel valve and inhibit conditions, plus
 * a count of lock commands seen on threshold 0.
 * assumes requests from the bench on clk_in and a synchronous reset.
 */
`timescale 1ns/1ns
module atm_engine_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [5:0] cond_req_in,
	input wire atm_pkg::atm_act_t [1:0] act_in,
	output atm_pkg::atm_cond_t cond_out,
	output logic [7:0] lock_cnt_out
);
	logic lock_q;
	// conditions move only on an edge, as the sequencer would do
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cond_out <= 6'h00;
			lock_q <= 1'b0;
			lock_cnt_out <= 8'h00;
		end else begin
			cond_out <= {cond_req_in[5:1], cond_req_in[1] & cond_req_in[0]};
			lock_q <= act_in[0].lock;
			if (act_in[0].lock && !lock_q) begin
				lock_cnt_out <= lock_cnt_out + 8'h01;
			end
		end
	end
endmodule : atm_engine_model

/* dv/atm_monitor_chk.sv */
/*
 * port assertions for the threshold monitor, with shadow copies of the
 * function and threshold 0 option writes.
 * assumes a bind onto atm_monitor and one clock domain.
 */
`timescale 1ns/1ns
module atm_monitor_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic [15:0] raw_in,
	input wire logic raw_valid_in,
	input wire atm_pkg::atm_cond_t cond_in,
	input wire logic [15:0] measure_out,
	input wire logic display_en_out,
	input wire atm_pkg::atm_act_t [1:0] act_out
);
	logic [2:0] func_reg;
	logic [15:0] opt_reg;
	wire logic fault_block;
	wire logic brk_block;
	wire logic inh_block;
	wire logic warn_off;
	wire logic deact_off;
	wire logic lock_off;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// shadows, so the gates are judged without looking inside
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			func_reg <= 3'h0;
			opt_reg <= 16'h0000;
		end else if (wr_in && addr_in == 8'h00) begin
			func_reg <= wdata_in[2:0];
		end else if (wr_in && addr_in == 8'h03) begin
			opt_reg <= wdata_in;
		end
	end
	// blocking conditions; act is registered, so judged one edge late
	assign fault_block = (opt_reg[8] && !cond_in.engine_running) ||
		(opt_reg[9] && !cond_in.oil_mask_expired) || (opt_reg[11] && !cond_in.fuel_valve_on);
	assign brk_block = opt_reg[10] && !cond_in.breaker_closed;
	assign inh_block = opt_reg[13] && cond_in.inhibit_present && cond_in.inhibit_active;
	assign warn_off = !opt_reg[4];
	assign deact_off = !opt_reg[6];
	assign lock_off = !opt_reg[7];
	a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
		else $error("read data not zero when idle");
	a_rdata_measure: assert property ($past(rd_in) && $past(addr_in) == 8'h09
		|-> rdata_out == $past(measure_out)) else $error("measure read wrong");
	a_measure_hold: assert property (!$past(raw_valid_in) |-> $stable(measure_out))
		else $error("measure moved without a sample");
	a_display_hidden: assert property (display_en_out == (func_reg != 3'h1))
		else $error("display enable wrong");
	a_pump_fault0: assert property (act_out[0].pump_off |-> act_out[0].fault)
		else $error("pump off without fault 0");
	a_pump_fault1: assert property (act_out[1].pump_off |-> act_out[1].fault)
		else $error("pump off without fault 1");
	a_fault_gates: assert property ($past(fault_block) |-> !act_out[0].fault)
		else $error("fault despite gate");
	a_brk_gate: assert property ($past(brk_block) |-> !(act_out[0].warn || act_out[0].lock))
		else $error("warn or lock with breaker open");
	a_inhibit_gate: assert property ($past(inh_block) |-> act_out[0][3:1] == 3'h0)
		else $error("action while inhibited");
	a_warn_off: assert property ($past(warn_off) |-> !act_out[0].warn)
		else $error("warn not enabled");
	a_deact_off: assert property ($past(deact_off) |-> !act_out[0].deact)
		else $error("deact not enabled");
	a_lock_off: assert property ($past(lock_off) |-> !act_out[0].lock)
		else $error("lock not enabled");
endmodule : atm_monitor_chk

/* dv/atm_monitor_tb_top.sv */
/*
 * self-checking bench for the threshold monitor: curves, delays, gates.
 * assumes the design, its package and the engine model compiled first.
 */
`timescale 1ns/1ns
module atm_monitor_tb_top;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [15:0] raw_in = 16'h0000;
	logic raw_valid_in = 1'b0;
	logic [5:0] cond_req = 6'h00;
	logic [15:0] rdata_out;
	logic [15:0] measure_out;
	logic display_en_out;
	logic [7:0] lock_cnt;
	atm_pkg::atm_cond_t cond_in;
	atm_pkg::atm_act_t [1:0] act_out;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	// preset function, raw ohm, expected converted value
	logic [2:0] p_fn [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	logic [15:0] p_raw [6] = '{16'h005f, 16'h00c3, 16'h0026, 16'h00b4, 16'h000a, 16'h005f};
	logic [15:0] p_exp [6] = '{16'h0005, 16'h0032, 16'h0064, 16'h0000, 16'h0064, 16'h0032};
	// option set, conditions, expected fault, warn, lock
	logic [15:0] g_opt [9] = '{16'h2590, 16'h2590, 16'h2590, 16'h2590, 16'h2590,
		16'h0a00, 16'h0a00, 16'h0a00, 16'h00d0};
	logic [5:0] g_cond [9] = '{6'h00, 6'h20, 6'h28, 6'h2a, 6'h2b, 6'h10, 6'h14, 6'h04, 6'h00};
	logic [2:0] g_exp [9] = '{3'h0, 3'h4, 3'h7, 3'h7, 3'h4, 3'h0, 3'h4, 3'h0, 3'h7};

	atm_monitor DUT (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.raw_in(raw_in), .raw_valid_in(raw_valid_in), .cond_in(cond_in),
		.measure_out(measure_out), .display_en_out(display_en_out), .act_out(act_out));
	atm_engine_model u_model (.clk_in(clk_in), .rst_in(rst_in), .cond_req_in(cond_req),
		.act_in(act_out), .cond_out(cond_in), .lock_cnt_out(lock_cnt));

	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// hang guard, far above the two hundred or so cycles the run needs
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			$display("ERROR %0t timeout", $time);
			n_errors = n_errors + 1;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	// one idle edge after each strobe keeps a signal to one update per step
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		check(rdata_out, exp, what);
	endtask : rd_chk
	task automatic sample(input logic [15:0] r);
		@(posedge clk_in);
		raw_in <= r;
		raw_valid_in <= 1'b1;
		@(posedge clk_in);
		raw_valid_in <= 1'b0;
		#1;
	endtask : sample
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : settle

	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		rd_chk(8'h07, 16'h0002, "npts reset");
		rd_chk(8'h03, 16'h0000, "opt reset");
		rd_chk(8'h3f, 16'h0000, "unmapped");
		check({15'h0000, display_en_out}, 16'h0001, "display reset");
		// generic curve 0..1000 ohm onto 0..100
		wr_reg(8'h40, 16'h0000);
		wr_reg(8'h41, 16'h03e8);
		wr_reg(8'h60, 16'h0000);
		wr_reg(8'h61, 16'h0064);
		sample(16'h01f4);
		check(measure_out, 16'h0032, "interpolate");
		rd_chk(8'h09, 16'h0032, "measure read");
		sample(16'h07d0);
		check(measure_out, 16'h00c8, "extend");
		for (int i = 0; i < 6; i++) begin
			wr_reg(8'h00, {13'h0000, p_fn[i]});
			sample(p_raw[i]);
			check(measure_out, p_exp[i], "preset");
		end
		// hidden function still feeds the thresholds
		wr_reg(8'h00, 16'h0001);
		settle(1);
		check({15'h0000, display_en_out}, 16'h0000, "hidden");
		sample(16'h012c);
		check(measure_out, 16'h001e, "hidden measure");
		wr_reg(8'h01, 16'h0028);
		wr_reg(8'h02, 16'h0014);
		wr_reg(8'h03, 16'h4010);
		wr_reg(8'h04, 16'h003c);
		wr_reg(8'h05, 16'h0000);
		wr_reg(8'h06, 16'h4043);
		sample(16'h01f4);
		settle(10);
		check({15'h0000, act_out[0].fault}, 16'h0000, "early fault");
		check({15'h0000, act_out[0].status}, 16'h0001, "idle status");
		check({13'h0000, act_out[1][5:4], act_out[1].deact}, 16'h0007, "thr1");
		settle(15);
		check({12'h000, act_out[0][5:3], act_out[0].pump_off}, 16'h0007, "thr0");
		sample(16'h012c);
		settle(3);
		check({15'h0000, act_out[0].fault}, 16'h0000, "back inside");
		sample(16'h01f4);
		settle(10);
		check({15'h0000, act_out[0].fault}, 16'h0000, "restart");
		settle(15);
		check({15'h0000, act_out[0].fault}, 16'h0001, "requalified");
		// gating and option combinations with no delay
		wr_reg(8'h02, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			wr_reg(8'h03, g_opt[i]);
			cond_req <= g_cond[i];
			settle(4);
			check({13'h0000, act_out[0].fault, act_out[0].warn, act_out[0].lock},
				{13'h0000, g_exp[i]}, "gates");
		end
		check({15'h0000, act_out[1].deact}, 16'h0001, "thr1 kept");
		rd_chk(8'h08, 16'hcd5e, "status word");
		check({8'h00, lock_cnt}, 16'h0002, "lock count");
		wr_reg(8'h07, 16'h0028);
		rd_chk(8'h07, 16'h0020, "npts clamp");
		conclude();
	end
endmodule : atm_monitor_tb_top

bind atm_monitor atm_monitor_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.raw_in(raw_in), .raw_valid_in(raw_valid_in), .cond_in(cond_in),
	.measure_out(measure_out), .display_en_out(display_en_out), .act_out(act_out));
